// >>> rtl/dcst_pkg.sv
// Package of timing constants and command codes for the DDR2 command-spacing controller
package dcst_pkg;
   // ---------------------------------------------------------------
   // Clock
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 100000;
   // ---------------------------------------------------------------
   // Times in their own units
   // ---------------------------------------------------------------
   localparam int TRFC_PS        = 127500;
   localparam int TXSNR_EXTRA_PS = 10000;
   localparam int TWTR_PS        = 7500;
   localparam int TRTP_PS        = 7500;
   localparam int TRAS_PS        = 40000;
   localparam int TMOD_MAX_PS    = 12000;
   localparam int TIS_PS         = 400;
   localparam int TIH_PS         = 400;
   // Round a least time up to whole cycles, never below one
   function automatic int ceil_cyc(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int TXSNR_CYC = ceil_cyc(TRFC_PS + TXSNR_EXTRA_PS);
   localparam int TWTR_CYC_RAW = ceil_cyc(TWTR_PS);
   localparam int TWTR_MIN_CK = 2;
   localparam int TWTR_CYC = (TWTR_CYC_RAW < TWTR_MIN_CK) ? TWTR_MIN_CK : TWTR_CYC_RAW;
   localparam int TRTP_CYC = ceil_cyc(TRTP_PS);
   localparam int TRAS_CYC = ceil_cyc(TRAS_PS);
   localparam int TMOD_CYC = ceil_cyc(TMOD_MAX_PS);
   localparam int TDELAY_CYC = ceil_cyc(TIS_PS + CLK_PERIOD_PS + TIH_PS);
   // ---------------------------------------------------------------
   // Counts in clock cycles, the counter width and the slow-exit mode bit index
   // ---------------------------------------------------------------
   localparam int TXSRD_CYC  = 200;
   localparam int TXP_CYC    = 2;
   localparam int TXARD_CYC  = 2;
   localparam int TXARDS_FAST_GRADE = 8;
   localparam int TXARDS_SLOW_GRADE = 7;
   localparam int TANPD_CYC  = 3;
   localparam int TAXPD_CYC  = 8;
   localparam int TMRD_CYC   = 2;
   localparam int TCKE_CYC   = 3;
   localparam int CNT_W      = 8;
   localparam int MR_SLOW_EXIT_BIT = 12;
   // ---------------------------------------------------------------
   // Commands
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      DCST_NOP   = 4'b0000,
      DCST_ACT   = 4'b0001,
      DCST_RD    = 4'b0010,
      DCST_WR    = 4'b0011,
      DCST_PRE   = 4'b0100,
      DCST_REF   = 4'b0101,
      DCST_MRS   = 4'b0110,
      DCST_PDE   = 4'b0111,
      DCST_PDX   = 4'b1000,
      DCST_SRE   = 4'b1001,
      DCST_SRX   = 4'b1010,
      DCST_ODTON = 4'b1011,
      DCST_ODTOF = 4'b1100
   } dcst_cmd_t;
   typedef enum logic [1:0] {
      DCST_ST_IDLE   = 2'b00,
      DCST_ST_ACTPD  = 2'b01,
      DCST_ST_PREPD  = 2'b10,
      DCST_ST_SELFR  = 2'b11
   } dcst_state_t;
endpackage

// >>> rtl/dcst_gap_timer.sv
// Down-counter that holds a dependent command until a spacing has elapsed
`timescale 1ns/1ps
`default_nettype none
module dcst_gap_timer #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         rst_b,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              done
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   // A load only ever lengthens the wait, so a short spacing never cuts a long
   // one that is still running; a load of n keeps done low for n cycles and the
   // dependent command goes on the edge after the count has emptied
   assign cnt_next = (load && (value > cnt_reg)) ? value
                   : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
   assign done     = (cnt_reg == '0);
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule // dcst_gap_timer
`default_nettype wire

// >>> rtl/dcst_ctrl.sv
// Host-side DDR2 command spacer: issues commands only when every spacing has elapsed
`timescale 1ns/1ps
`default_nettype none
module dcst_ctrl #(
   parameter int          AL          = 0,
   parameter int          BL          = 4,
   parameter bit          FAST_GRADE  = 1'b1,
   parameter logic [15:0] MR_INIT     = 16'h0000
) (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        req_valid,
   input  wire logic [3:0]  req_cmd,
   input  wire logic [15:0] req_addr,
   input  wire logic        req_mr_is_main,
   input  wire logic        refresh_missed,
   output logic             req_ready,
   output logic             data_suspect,
   output logic [3:0]       cmd_out,
   output logic [15:0]      addr_out,
   output logic             cke,
   output logic             odt,
   output logic             clk_en,
   output logic [1:0]       pwr_state
);
   localparam int W = dcst_pkg::CNT_W;
   // Constraint indices, one timer each
   localparam int T_NONRD = 0;
   localparam int T_RD    = 1;
   localparam int T_PDE   = 2;
   localparam int T_MRD   = 3;
   localparam int T_CKE   = 4;
   localparam int T_PRE   = 5;
   localparam int T_ODTS  = 6;
   localparam int T_CLK   = 7;
   localparam int NT      = 8;
   localparam int XARDS   = (FAST_GRADE ? dcst_pkg::TXARDS_FAST_GRADE
                                        : dcst_pkg::TXARDS_SLOW_GRADE) - AL;
   localparam int RDPRE   = AL + BL / 2;
   localparam int RD2PRE  = (RDPRE > dcst_pkg::TRTP_CYC) ? RDPRE : dcst_pkg::TRTP_CYC;

   function automatic logic [W-1:0] cyc(input int n);
      return (n < 1) ? W'(1) : W'(n);
   endfunction

   logic [NT-1:0]       t_load;
   logic [NT-1:0]       t_done;
   logic [W-1:0]        t_val [NT];
   logic                cke_reg;
   logic                odt_reg;
   logic                suspect_reg;
   logic                slow_exit;
   logic [3:0]          cmd_reg;
   logic [15:0]         addr_reg;
   logic [15:0]         mr_reg;
   dcst_pkg::dcst_state_t state_reg;
   dcst_pkg::dcst_state_t state_next;
   logic                take;
   logic                ok;
   logic                is_rd;
   logic                is_wr;
   logic                is_pre;
   logic                is_act;
   logic                is_mrs;
   logic                is_pde;
   logic                is_pdx;
   logic                is_sre;
   logic                is_srx;
   logic                is_odt;
   logic                cke_change;
   logic                legal_in_state;

   // ---------------------------------------------------------------
   // One timer per spacing
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_tmr
         dcst_gap_timer #(.W(W)) u_tmr (
            .clock (clock),
            .rst_b (rst_b),
            .load  (t_load[gi]),
            .value (t_val[gi]),
            .done  (t_done[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   assign is_rd  = (req_cmd == dcst_pkg::DCST_RD);
   assign is_wr  = (req_cmd == dcst_pkg::DCST_WR);
   assign is_pre = (req_cmd == dcst_pkg::DCST_PRE);
   assign is_act = (req_cmd == dcst_pkg::DCST_ACT);
   assign is_mrs = (req_cmd == dcst_pkg::DCST_MRS);
   assign is_pde = (req_cmd == dcst_pkg::DCST_PDE);
   assign is_pdx = (req_cmd == dcst_pkg::DCST_PDX);
   assign is_sre = (req_cmd == dcst_pkg::DCST_SRE);
   assign is_srx = (req_cmd == dcst_pkg::DCST_SRX);
   assign is_odt = (req_cmd == dcst_pkg::DCST_ODTON) || (req_cmd == dcst_pkg::DCST_ODTOF);
   assign cke_change = is_pde || is_pdx || is_sre || is_srx;

   // Powered-down states accept only their exit; awake state refuses exits
   assign legal_in_state =
      (state_reg == dcst_pkg::DCST_ST_IDLE)  ? !(is_pdx || is_srx) :
      (state_reg == dcst_pkg::DCST_ST_SELFR) ? is_srx : is_pdx;

   // ---------------------------------------------------------------
   // Spacing gate
   // ---------------------------------------------------------------
   // Reads wait on the read timer, every other command on the non-read timer;
   // ODT moves also wait until synchronous ODT timing is back after a power-down exit
   assign ok = legal_in_state
             && (is_rd ? t_done[T_RD] : t_done[T_NONRD])
             && (!is_pde || t_done[T_PDE])
             && (!is_mrs || t_done[T_MRD])
             && (!is_odt || t_done[T_ODTS])
             && (!cke_change || t_done[T_CKE])
             && (!is_pre || t_done[T_PRE])
             && (!(is_pde || is_sre) || t_done[T_CLK])
             && (!is_rd || !suspect_reg);
   assign req_ready = ok;
   assign take      = req_valid && ok;

   // ---------------------------------------------------------------
   // Timer loads
   // ---------------------------------------------------------------
   always_comb begin
      t_load = '0;
      for (int i = 0; i < NT; i++) begin
         t_val[i] = '0;
      end
      if (take) begin
         // Exits arm the non-read and the read spacing together
         if (is_srx) begin
            t_load[T_NONRD] = 1'b1;
            t_val[T_NONRD]  = cyc(dcst_pkg::TXSNR_CYC);
            t_load[T_RD]    = 1'b1;
            t_val[T_RD]     = cyc(dcst_pkg::TXSRD_CYC);
         end else if (is_pdx) begin
            t_load[T_NONRD] = 1'b1;
            t_val[T_NONRD]  = cyc(dcst_pkg::TXP_CYC);
            t_load[T_RD]    = 1'b1;
            // Precharge power-down has no read figure of its own beyond the exit spacing
            if (state_reg == dcst_pkg::DCST_ST_PREPD) begin
               t_val[T_RD] = cyc(dcst_pkg::TXP_CYC);
            end else if (slow_exit) begin
               t_val[T_RD] = cyc(XARDS);
            end else begin
               t_val[T_RD] = cyc(dcst_pkg::TXARD_CYC);
            end
            t_load[T_ODTS]  = 1'b1;
            t_val[T_ODTS]   = cyc(dcst_pkg::TAXPD_CYC);
         end else if (is_wr) begin
            // A long read hold left by a self-refresh exit still wins here
            t_load[T_RD]    = 1'b1;
            t_val[T_RD]     = cyc(dcst_pkg::TWTR_CYC);
         end else if (is_rd) begin
            t_load[T_PRE]   = 1'b1;
            t_val[T_PRE]    = cyc(RD2PRE);
         end else if (is_act) begin
            t_load[T_PRE]   = 1'b1;
            t_val[T_PRE]    = cyc(dcst_pkg::TRAS_CYC);
         end else if (is_mrs) begin
            t_load[T_MRD]   = 1'b1;
            t_val[T_MRD]    = cyc(dcst_pkg::TMRD_CYC);
            // Hold off further non-read commands until a new ODT value has surely landed
            t_load[T_NONRD] = 1'b1;
            t_val[T_NONRD]  = cyc(dcst_pkg::TMOD_CYC);
         end else if (is_odt) begin
            t_load[T_PDE]   = 1'b1;
            t_val[T_PDE]    = cyc(dcst_pkg::TANPD_CYC);
         end
         // Every CKE move opens its three-edge registration window
         if (cke_change) begin
            t_load[T_CKE]   = 1'b1;
            t_val[T_CKE]    = cyc(dcst_pkg::TCKE_CYC);
         end
         // CKE falling: the memory clock must stay alive for the hold time
         if (is_pde || is_sre) begin
            t_load[T_CLK]   = 1'b1;
            t_val[T_CLK]    = cyc(dcst_pkg::TDELAY_CYC);
         end
      end
   end

   // ---------------------------------------------------------------
   // Power state
   // ---------------------------------------------------------------
   // Only a taken command moves the state; refused ones leave it alone
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dcst_pkg::DCST_ST_IDLE: begin
            if (take && is_pde) begin
               state_next = dcst_pkg::DCST_ST_ACTPD;
            end else if (take && is_sre) begin
               state_next = dcst_pkg::DCST_ST_SELFR;
            end
         end
         dcst_pkg::DCST_ST_ACTPD, dcst_pkg::DCST_ST_PREPD: begin
            if (take && is_pdx) begin
               state_next = dcst_pkg::DCST_ST_IDLE;
            end
         end
         dcst_pkg::DCST_ST_SELFR: begin
            if (take && is_srx) begin
               state_next = dcst_pkg::DCST_ST_IDLE;
            end
         end
         default: begin
            state_next = dcst_pkg::DCST_ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registered pins
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_reg <= dcst_pkg::DCST_ST_IDLE;
         cmd_reg   <= dcst_pkg::DCST_NOP;
         addr_reg  <= 16'h0000;
         cke_reg   <= 1'b1;
         odt_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cmd_reg   <= take ? req_cmd : dcst_pkg::DCST_NOP;
         addr_reg  <= take ? req_addr : addr_reg;
         if (take && (is_pde || is_sre)) begin
            cke_reg <= 1'b0;
         end else if (take && (is_pdx || is_srx)) begin
            cke_reg <= 1'b1;
         end
         if (take && req_cmd == dcst_pkg::DCST_ODTON) begin
            odt_reg <= 1'b1;
         end else if (take && req_cmd == dcst_pkg::DCST_ODTOF) begin
            odt_reg <= 1'b0;
         end
      end
   end

   // Mode copy and refresh-loss flag; a miss in the clearing cycle still sets
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mr_reg        <= MR_INIT;
         suspect_reg   <= 1'b0;
      end else begin
         // Only the main mode register carries the exit-speed bit
         if (take && is_mrs && req_mr_is_main) begin
            mr_reg        <= req_addr;
         end
         if (refresh_missed) begin
            suspect_reg <= 1'b1;
         end else if (take && is_wr) begin
            suspect_reg <= 1'b0;
         end
      end
   end

   assign cmd_out      = cmd_reg;
   assign addr_out     = addr_reg;
   assign cke          = cke_reg;
   assign odt          = odt_reg;
   // Clock stops only in self-refresh once the hold time after CKE low is met
   assign clk_en       = !((state_reg == dcst_pkg::DCST_ST_SELFR) && t_done[T_CLK]);
   assign pwr_state    = state_reg;
   assign data_suspect = suspect_reg;
   // Exit speed follows the stored mode word, so the reset value can preselect it
   assign slow_exit    = mr_reg[dcst_pkg::MR_SLOW_EXIT_BIT];
endmodule // dcst_ctrl
`default_nettype wire

// >>> verification/dcst_dev_model.sv
// Behavioural DDR2 device that counts spacing faults seen on its command port
`timescale 1ns/1ps
`default_nettype none
module dcst_dev_model #(
   parameter int AL = 0,
   parameter int BL = 4
) (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic [3:0]  cmd,
   input  wire logic [15:0] addr,
   input  wire logic        cke,
   input  wire logic        odt,
   output wire logic        term_on,
   output logic [7:0]       viol_cnt
);
   // Ages: 0 write, 1 read, 2 mode set, 3 ODT, 4 CKE, 5 self-refresh exit, 6 power-down exit
   int         age [0:6];
   int         bad;
   logic       cke_q, odt_q, slow_q, on_q, off_q;
   logic [1:0] odt_sh;
   // ----------------------------------------------------------------
   // Spacing checks; ages restart at 1 on the edge that registers the cause
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      if (!rst_b) begin
         foreach (age[i]) age[i] = 1000;
         {cke_q, odt_q, slow_q, on_q, odt_sh} = 6'h20;
         viol_cnt <= 8'h00;
      end else begin
         bad = (cmd == dcst_pkg::DCST_RD && age[0] < dcst_pkg::TWTR_CYC);
         bad += (cmd == dcst_pkg::DCST_PRE && age[1] < AL + BL / 2);
         bad += (cmd == dcst_pkg::DCST_PRE && age[1] < dcst_pkg::TRTP_CYC);
         bad += (cmd == dcst_pkg::DCST_MRS && age[2] < dcst_pkg::TMRD_CYC);
         bad += (cmd == dcst_pkg::DCST_PDE && age[3] < dcst_pkg::TANPD_CYC);
         bad += (cke != cke_q && age[4] < dcst_pkg::TCKE_CYC);
         bad += (cmd == dcst_pkg::DCST_RD && age[5] < dcst_pkg::TXSRD_CYC);
         bad += (cmd != dcst_pkg::DCST_RD && cmd != dcst_pkg::DCST_NOP
                 && age[5] < dcst_pkg::TXSNR_CYC);
         bad += (cmd != dcst_pkg::DCST_NOP && age[6] < dcst_pkg::TXP_CYC);
         // Slow figure assumes the faster grade, as the bench builds it
         bad += (cmd == dcst_pkg::DCST_RD && age[6] < (slow_q ?
                 dcst_pkg::TXARDS_FAST_GRADE - AL : dcst_pkg::TXARD_CYC));
         foreach (age[i]) age[i]++;
         if (cmd == dcst_pkg::DCST_WR) age[0] = 1;
         if (cmd == dcst_pkg::DCST_RD) age[1] = 1;
         if (cmd == dcst_pkg::DCST_MRS) age[2] = 1;
         if (cmd == dcst_pkg::DCST_MRS) slow_q = addr[dcst_pkg::MR_SLOW_EXIT_BIT];
         if (odt != odt_q) age[3] = 1;
         if (cke != cke_q) age[4] = 1;
         if (cmd == dcst_pkg::DCST_SRX) age[5] = 1;
         if (cmd == dcst_pkg::DCST_PDX) age[6] = 1;
         on_q <= odt_sh[1];
         {cke_q, odt_q} = {cke, odt};
         odt_sh = {odt_sh[0], odt};
         viol_cnt <= viol_cnt + 8'(bad);
      end
   end
   // Turn-off lags half a cycle behind the registered off edge
   always @(negedge clock) off_q <= on_q;
   assign term_on = on_q | off_q;
endmodule // dcst_dev_model
`default_nettype wire

// >>> verification/dcst_ctrl_monitor.sv
// Checker of command spacing seen at the controller ports
`timescale 1ns/1ps
`default_nettype none
module dcst_ctrl_monitor #(
   parameter int AL = 0,
   parameter int BL = 4
) (
   input wire logic       clock,
   input wire logic       rst_b,
   input wire logic       req_valid,
   input wire logic [3:0] req_cmd,
   input wire logic       req_ready,
   input wire logic       data_suspect,
   input wire logic [3:0] cmd_out,
   input wire logic       cke,
   input wire logic       odt,
   input wire logic       clk_en
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Saturating ages since a read and a self-refresh exit left the port
   logic [7:0] rd_age_reg, srx_age_reg;
   wire logic [7:0] rd_age_next = (cmd_out == dcst_pkg::DCST_RD) ? 8'h01 :
                                  (rd_age_reg == 8'hff) ? 8'hff : rd_age_reg + 8'h01;
   wire logic [7:0] srx_age_next = (cmd_out == dcst_pkg::DCST_SRX) ? 8'h01 :
                                   (srx_age_reg == 8'hff) ? 8'hff : srx_age_reg + 8'h01;
   always_ff @(posedge clock) begin
      rd_age_reg <= rst_b ? rd_age_next : 8'hff;
      srx_age_reg <= rst_b ? srx_age_next : 8'hff;
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_take_shows_cmd: assert property (req_valid && req_ready |=> cmd_out == $past(req_cmd))
      else $error("taken request not shown on cmd_out");
   a_wr_rd_gap: assert property (cmd_out == dcst_pkg::DCST_WR |=> cmd_out != dcst_pkg::DCST_RD)
      else $error("read too soon after write");
   a_mrs_gap: assert property (cmd_out == dcst_pkg::DCST_MRS |=> cmd_out != dcst_pkg::DCST_MRS)
      else $error("mode sets too close");
   a_rd_pre_gap: assert property (cmd_out == dcst_pkg::DCST_PRE |-> rd_age_reg >= AL + BL / 2)
      else $error("precharge too soon after read");
   a_odt_pde_gap: assert property ($changed(odt) |-> (cmd_out != dcst_pkg::DCST_PDE) [*3])
      else $error("power-down too soon after ODT change");
   a_cke_hold: assert property ($changed(cke) |=> $stable(cke) [*2])
      else $error("CKE changed before three edges");
   a_clk_hold: assert property ($fell(cke) |-> clk_en ##1 clk_en)
      else $error("clock stopped too soon after CKE fell");
   a_srx_rd_gap: assert property (cmd_out == dcst_pkg::DCST_RD |-> srx_age_reg >= dcst_pkg::TXSRD_CYC)
      else $error("read too soon after self-refresh exit");
   a_pdx_rd_gap: assert property (cmd_out == dcst_pkg::DCST_PDX |=> cmd_out != dcst_pkg::DCST_RD)
      else $error("read too soon after power-down exit");
   a_suspect_block: assert property (data_suspect && req_valid && req_cmd == dcst_pkg::DCST_RD
                                     |-> !req_ready)
      else $error("read accepted while data suspect");
   c_srx: cover property (cmd_out == dcst_pkg::DCST_SRX);
   c_pde: cover property (cmd_out == dcst_pkg::DCST_PDE);
   c_suspect: cover property (data_suspect);
endmodule // dcst_ctrl_monitor
bind dcst_ctrl dcst_ctrl_monitor #(.AL(AL), .BL(BL)) mon_u (
   .clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req_cmd(req_cmd),
   .req_ready(req_ready), .data_suspect(data_suspect), .cmd_out(cmd_out),
   .cke(cke), .odt(odt), .clk_en(clk_en)
);
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the DDR2 command spacer against a device model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int AL = 0;
   localparam int BL = 4;
   logic             clock, rst_b, req_valid, req_mr_is_main, refresh_missed, slow;
   logic [3:0]       req_cmd;
   logic [15:0]      req_addr;
   wire logic        req_ready, data_suspect, cke, odt, clk_en, term_on;
   wire logic [3:0]  cmd_out;
   wire logic [15:0] addr_out;
   wire logic [1:0]  pwr_state;
   wire logic [7:0]  viol_cnt;
   int               error_cnt = 0;
   int               comparisons = 0;
   longint           last_t = 0;
   logic [31:0]      seed = 32'h1af5;
   dcst_ctrl #(.AL(AL), .BL(BL), .FAST_GRADE(1'b1), .MR_INIT(16'h0000)) dut_u (
      .clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_mr_is_main(req_mr_is_main),
      .refresh_missed(refresh_missed), .req_ready(req_ready), .data_suspect(data_suspect),
      .cmd_out(cmd_out), .addr_out(addr_out), .cke(cke), .odt(odt), .clk_en(clk_en),
      .pwr_state(pwr_state));
   dcst_dev_model #(.AL(AL), .BL(BL)) dev_u (
      .clock(clock), .rst_b(rst_b), .cmd(cmd_out), .addr(addr_out), .cke(cke),
      .odt(odt), .term_on(term_on), .viol_cnt(viol_cnt));
   // ----------------------------------------------------------------
   // Clock, watchdog and helpers
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Whole run needs under 1000 cycles; a stuck ready ends here
   initial begin
      #300000;
      error_cnt++;
      report_and_stop();
   end
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   function automatic int maxi(input int a, input int b);
      return (a > b) ? a : b;
   endfunction
   task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_gap(input string nm, input int e, input int g);
      comparisons++;
      if (g != e) begin
         error_cnt++;
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   // Hold the request until ready, then compare the cycles since the last take
   task automatic send(input logic [3:0] c, input int eg);
      logic [15:0] a;
      int          n;
      a = rnd();
      if (c == dcst_pkg::DCST_MRS) a[dcst_pkg::MR_SLOW_EXIT_BIT] = slow;
      @(posedge clock);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_addr <= a;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (req_ready !== 1'b1 && n < 500);
      @(posedge clock);
      req_valid <= 1'b0;
      n = int'(($time - last_t) / 100);
      last_t = $time;
      @(negedge clock);
      chk_val("cmd_out", c, cmd_out);
      chk_val("addr_out", a, addr_out);
      // A spacing of n frees its dependent on the edge after the counter empties
      if (eg > 0) chk_gap("gap", eg + 1, n);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_b, req_valid, req_mr_is_main, refresh_missed, slow} = 5'h04;
      req_cmd = 4'h0;
      req_addr = 16'h0000;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      @(negedge clock);
      chk_val("reset_state", 16'h0024,
              {6'h00, cmd_out, cke, odt, data_suspect, clk_en, pwr_state});
      chk_val("addr_out", 16'h0000, addr_out);
      send(dcst_pkg::DCST_WR, 0);
      send(dcst_pkg::DCST_RD, maxi(dcst_pkg::TWTR_CYC, 2));
      send(dcst_pkg::DCST_ACT, 0);
      send(dcst_pkg::DCST_RD, 0);
      send(dcst_pkg::DCST_PRE, maxi(maxi(AL + BL / 2, dcst_pkg::TRTP_CYC), 2));
      send(dcst_pkg::DCST_MRS, 0);
      send(dcst_pkg::DCST_MRS, maxi(dcst_pkg::TMRD_CYC, 2));
      send(dcst_pkg::DCST_ODTON, 0);
      chk_val("odt", 16'h0001, odt);
      send(dcst_pkg::DCST_PDE, dcst_pkg::TANPD_CYC);
      chk_val("pwr_cke", 16'h0002, {pwr_state, cke});
      send(dcst_pkg::DCST_PDX, dcst_pkg::TCKE_CYC);
      send(dcst_pkg::DCST_RD, maxi(dcst_pkg::TXARD_CYC, 2));
      slow = 1'b1;
      send(dcst_pkg::DCST_MRS, 0);
      send(dcst_pkg::DCST_ODTOF, 0);
      send(dcst_pkg::DCST_PDE, dcst_pkg::TANPD_CYC);
      send(dcst_pkg::DCST_PDX, dcst_pkg::TCKE_CYC);
      send(dcst_pkg::DCST_RD, dcst_pkg::TXARDS_FAST_GRADE - AL);
      send(dcst_pkg::DCST_SRE, 0);
      chk_val("clk_en", 16'h0001, clk_en);
      send(dcst_pkg::DCST_SRX, dcst_pkg::TCKE_CYC);
      send(dcst_pkg::DCST_WR, maxi(dcst_pkg::TXSNR_CYC, 2));
      send(dcst_pkg::DCST_SRE, 0);
      send(dcst_pkg::DCST_SRX, dcst_pkg::TCKE_CYC);
      send(dcst_pkg::DCST_RD, dcst_pkg::TXSRD_CYC);
      // Missed refresh: reads wait until a write restores the data
      @(posedge clock);
      refresh_missed <= 1'b1;
      @(posedge clock);
      refresh_missed <= 1'b0;
      req_valid <= 1'b1;
      req_cmd <= dcst_pkg::DCST_RD;
      repeat (3) begin
         @(negedge clock);
         chk_val("suspect_ready", 16'h0002, {data_suspect, req_ready});
      end
      @(posedge clock);
      req_valid <= 1'b0;
      send(dcst_pkg::DCST_WR, 0);
      chk_val("data_suspect", 16'h0000, data_suspect);
      send(dcst_pkg::DCST_RD, maxi(dcst_pkg::TWTR_CYC, 2));
      // Let the device model register the last command before reading its count
      @(negedge clock);
      chk_val("viol_cnt", 16'h0000, viol_cnt);
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
